// File: hdl/simov_monitor.sv
// Module: over-voltage handling, input settings and polling of the monitor
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Over-voltage entry turns all wetting currents off and halts monitoring.
// - Over-voltage entry asserts the event line and sets the event bit.
// - Live over-voltage flag reads one while the condition lasts.
// - Any-event flag rides on every read while an event is pending.
// - Event line and event register clear after a transfer reading them.
// - Bus access and all register contents stay intact during over-voltage.
// - Condition holds until the comparator drops; no repeat event meanwhile.
// - Over-voltage exit sets the event bit again and clears the live flag.
// - After recovery, resume current settings from lowest enabled input.
// - First polling cycle after recovery raises change event, sets baseline.
// - Open or closed state of all 24 inputs is readable.
// - Thresholds shared per four inputs; wetting fields per pair, some single.
// - Each group picks one of four levels for the open/closed decision.
// - Inputs 10 to 23 use sources only, no sink option.
// - Select bit one picks sink, zero picks source, inputs 0 to 9.
// - Source or sink selects reset to zero.
// - Enable bit zero turns off wetting and excludes the input.
// - All enable bits reset to zero.
// - Each wetting field selects one of six currents for its inputs.
// - Wetting fields reset to zero milliamps.
// - Monitor-go starts wetting and monitoring; clearing it stops both.
module simov_monitor
  import simov_pkg::*;
(
  input  wire logic                                  ref_clk,
  input  wire logic                                  rst,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [7:0]                            paddr,
  input  wire logic [31:0]                           pwdata,
  output logic [31:0]                                prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  input  wire logic                                  ovDetect,
  input  wire logic                                  pollClk,
  input  wire logic [simov_pkg::NUM_INPUTS*simov_pkg::NUM_LEVELS-1:0] inAbove,
  output logic [simov_pkg::NUM_INPUTS-1:0]           wettingOn,
  output logic [simov_pkg::NUM_INPUTS-1:0]           sinkSel,
  output logic [simov_pkg::NUM_INPUTS*simov_pkg::WC_W-1:0] wettingCode,
  output logic                                       eventReqNOut,
  output logic                                       eventReqNOe
);
  import simov_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int NSYNC = NUM_INPUTS * NUM_LEVELS + 2;
  logic [NSYNC-1:0] syncA_q;
  logic [NSYNC-1:0] syncB_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= {ovDetect, pollClk, inAbove};
      syncB_q <= syncA_q;
    end
  end
  logic                               ovLevel;
  logic                               pollLevel;
  logic [NUM_INPUTS*NUM_LEVELS-1:0]   aboveLevel;
  assign ovLevel    = syncB_q[NSYNC-1];
  assign pollLevel  = syncB_q[NSYNC-2];
  assign aboveLevel = syncB_q[NUM_INPUTS*NUM_LEVELS-1:0];

  logic ovPrev_q;
  logic pollPrev_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovPrev_q   <= 1'b0;
      pollPrev_q <= 1'b0;
    end else begin
      ovPrev_q   <= ovLevel;
      pollPrev_q <= pollLevel;
    end
  end
  logic ovEnter;
  logic ovExit;
  logic pollTick;
  // Only edges raise events, so a held condition never re-raises
  assign ovEnter  = ovLevel & ~ovPrev_q;
  assign ovExit   = ~ovLevel & ovPrev_q;
  assign pollTick = pollLevel & ~pollPrev_q;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic        goQ_q;
  logic [23:0] inEn_q;
  logic [9:0]  csSel_q;
  logic [11:0] thresh_q;
  logic [44:0] wc_q;
  logic        ovEvent_q;
  logic        scEvent_q;
  logic        ovLive_q;
  logic [23:0] swStat_q;
  logic [31:0] rdata_q;
  logic        rdErr_q;

  logic setupPh;
  logic accessPh;
  logic wrDone;
  logic evReadDone;
  logic mapped;
  logic cfgOpen;
  assign setupPh    = psel & ~penable;
  assign accessPh   = psel & penable;
  assign pready     = accessPh;
  assign pslverr    = accessPh & rdErr_q;
  assign prdata     = rdata_q;
  assign wrDone     = accessPh & pwrite & ~rdErr_q;
  assign evReadDone = accessPh & ~pwrite & (paddr == OFF_EVENT);
  // Settings are frozen while monitoring runs
  assign cfgOpen    = ~goQ_q;

  always_comb begin
    case (paddr)
      OFF_CONFIG, OFF_EVENT, OFF_MISC, OFF_SWSTAT, OFF_IN_EN,
      OFF_CS_SEL, OFF_THRESH, OFF_WC_A, OFF_WC_B: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  logic [31:0] rdMux;
  logic        anyEvent;
  assign anyEvent = ovEvent_q | scEvent_q;
  always_comb begin
    rdMux = 32'h00000000;
    case (paddr)
      OFF_CONFIG: rdMux[BIT_GO] = goQ_q;
      OFF_EVENT: begin
        rdMux[BIT_OV_EVENT] = ovEvent_q;
        rdMux[BIT_SC_EVENT] = scEvent_q;
      end
      OFF_MISC:   rdMux[BIT_OV_LIVE] = ovLive_q;
      OFF_SWSTAT: rdMux[23:0] = swStat_q;
      OFF_IN_EN:  rdMux[23:0] = inEn_q;
      OFF_CS_SEL: rdMux[9:0] = csSel_q;
      OFF_THRESH: rdMux[11:0] = thresh_q;
      OFF_WC_A:   rdMux[23:0] = wc_q[23:0];
      OFF_WC_B:   rdMux[20:0] = wc_q[44:24];
      default:    rdMux = 32'h00000000;
    endcase
    rdMux[BIT_ANY_EVENT] = anyEvent;
  end

  // Read data is captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
      rdErr_q <= 1'b0;
    end else if (setupPh) begin
      rdata_q <= pwrite ? 32'h00000000 : rdMux;
      rdErr_q <= ~mapped;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      goQ_q <= 1'b0;
    end else if (wrDone && paddr == OFF_CONFIG) begin
      goQ_q <= pwdata[BIT_GO];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      inEn_q   <= RST_IN_EN;
      csSel_q  <= RST_CS_SEL;
      thresh_q <= RST_THRESH;
      wc_q     <= RST_WC;
    end else if (wrDone && cfgOpen) begin
      case (paddr)
        OFF_IN_EN:  inEn_q <= pwdata[23:0];
        OFF_CS_SEL: csSel_q <= pwdata[9:0];
        OFF_THRESH: thresh_q <= pwdata[11:0];
        OFF_WC_A:   wc_q[23:0] <= pwdata[23:0];
        OFF_WC_B:   wc_q[44:24] <= pwdata[20:0];
        default:    inEn_q <= inEn_q;
      endcase
    end
  end

  // ****************************************************************
  // Per-input drive and comparison
  // ****************************************************************
  logic active;
  logic [NUM_INPUTS-1:0] inState;
  // Over-voltage halts wetting and polling but keeps settings for recovery
  assign active = goQ_q & ~ovLive_q;

  always_comb begin
    for (int i = 0; i < NUM_INPUTS; i++) begin
      wettingOn[i] = active & inEn_q[i];
      // No sink path exists above the sinkable range
      sinkSel[i] = (i < NUM_SINKABLE) ? csSel_q[i] : 1'b0;
      wettingCode[i*WC_W +: WC_W] = wc_q[WC_MAP[i]*WC_W +: WC_W];
      // Group level picks one comparator tap
      inState[i] = aboveLevel[i*NUM_LEVELS +
                   thresh_q[(i/GROUP_SIZE)*THR_W +: THR_W]];
    end
  end

  // ****************************************************************
  // Polling
  // ****************************************************************
  logic [IDX_W-1:0] idx_q;
  logic             firstCycle_q;
  logic             changed_q;
  logic             goPrev_q;
  logic             restart;
  assign restart = (goQ_q & ~goPrev_q) | ovExit;

  function automatic logic [IDX_W:0] nextEn(input logic [23:0] en,
                                            input int from);
    logic [IDX_W:0] r;
    r = 6'h3F;
    for (int k = NUM_INPUTS - 1; k >= 0; k--) begin
      if (k >= from && en[k]) begin
        r = 6'(k);
      end
    end
    return r;
  endfunction : nextEn

  logic [IDX_W:0] firstEn;
  logic [IDX_W:0] afterCur;
  logic           sampleNow;
  logic           cycleEnd;
  assign firstEn   = nextEn(inEn_q, 0);
  assign afterCur  = nextEn(inEn_q, int'(idx_q) + 1);
  assign sampleNow = active & pollTick & ~firstEn[IDX_W];
  assign cycleEnd  = sampleNow & afterCur[IDX_W];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      goPrev_q <= 1'b0;
    end else begin
      goPrev_q <= goQ_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idx_q <= 5'h00;
    end else if (restart) begin
      idx_q <= 5'h00;
    end else if (sampleNow) begin
      idx_q <= cycleEnd ? 5'h00 : afterCur[IDX_W-1:0];
    end
  end

  logic [IDX_W-1:0] cur;
  assign cur = (idx_q < firstEn[IDX_W-1:0]) ? firstEn[IDX_W-1:0] : idx_q;

  // Status register only moves on a real sample; otherwise it holds
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      swStat_q <= 24'h000000;
    end else if (sampleNow) begin
      swStat_q[cur] <= inState[cur];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      firstCycle_q <= 1'b0;
      changed_q    <= 1'b0;
    end else if (ovExit) begin
      firstCycle_q <= 1'b1;
      changed_q    <= 1'b0;
    end else if (restart) begin
      firstCycle_q <= 1'b0;
      changed_q    <= 1'b0;
    end else if (cycleEnd) begin
      firstCycle_q <= 1'b0;
      changed_q    <= 1'b0;
    end else if (sampleNow && swStat_q[cur] != inState[cur]) begin
      changed_q <= 1'b1;
    end
  end

  logic scSet;
  // Recovery cycle always reports; its samples become the new baseline
  assign scSet = cycleEnd & (firstCycle_q | changed_q |
                 (swStat_q[cur] != inState[cur]));

  // ****************************************************************
  // Over-voltage state and events
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovLive_q <= 1'b0;
    end else if (ovEnter) begin
      ovLive_q <= 1'b1;
    end else if (ovExit) begin
      ovLive_q <= 1'b0;
    end
  end

  // A new event in the clearing cycle wins over the clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovEvent_q <= 1'b0;
    end else if (ovEnter || ovExit) begin
      ovEvent_q <= 1'b1;
    end else if (evReadDone) begin
      ovEvent_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scEvent_q <= 1'b0;
    end else if (scSet) begin
      scEvent_q <= 1'b1;
    end else if (evReadDone) begin
      scEvent_q <= 1'b0;
    end
  end

  // Open-drain event line: only ever pulled low
  assign eventReqNOut = 1'b0;
  assign eventReqNOe  = anyEvent;

endmodule : simov_monitor
`default_nettype wire

// File: hdl/simov_pkg.sv
// Package: register map, field layout and reset values of the switch monitor
package simov_pkg;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_INPUTS   = 24;
  localparam int NUM_SINKABLE = 10;
  localparam int NUM_GROUPS   = 6;
  localparam int GROUP_SIZE   = 4;
  localparam int NUM_LEVELS   = 4;
  localparam int NUM_WC       = 15;
  localparam int WC_W         = 3;
  localparam int THR_W        = 2;
  localparam int IDX_W        = 5;
  localparam int WC_A_FIELDS  = 8;
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_EVENT  = 8'h04;
  localparam logic [7:0] OFF_MISC   = 8'h08;
  localparam logic [7:0] OFF_SWSTAT = 8'h0C;
  localparam logic [7:0] OFF_IN_EN  = 8'h10;
  localparam logic [7:0] OFF_CS_SEL = 8'h14;
  localparam logic [7:0] OFF_THRESH = 8'h18;
  localparam logic [7:0] OFF_WC_A   = 8'h1C;
  localparam logic [7:0] OFF_WC_B   = 8'h20;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_GO        = 0;
  localparam int BIT_OV_EVENT  = 0;
  localparam int BIT_SC_EVENT  = 1;
  localparam int BIT_OV_LIVE   = 0;
  localparam int BIT_ANY_EVENT = 31;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [23:0] RST_IN_EN  = 24'h000000;
  localparam logic [9:0]  RST_CS_SEL = 10'h000;
  localparam logic [11:0] RST_THRESH = 12'h000;
  localparam logic [44:0] RST_WC     = 45'h0;
  // Wetting current codes, ascending current from code zero
  localparam logic [2:0] WC_0MA  = 3'h0;
  localparam logic [2:0] WC_1MA  = 3'h1;
  localparam logic [2:0] WC_2MA  = 3'h2;
  localparam logic [2:0] WC_5MA  = 3'h3;
  localparam logic [2:0] WC_10MA = 3'h4;
  localparam logic [2:0] WC_15MA = 3'h5;
  // Wetting field used by each input, inputs 0..23
  localparam logic [3:0] WC_MAP [NUM_INPUTS] = '{
    4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5,
    4'h6, 4'h7, 4'h8, 4'h8, 4'h9, 4'h9, 4'hA, 4'hA, 4'hB, 4'hB,
    4'hC, 4'hC, 4'hD, 4'hE};
endpackage : simov_pkg

// File: tb/simov_front.sv
// Model: switch front end, poll clock and pulled-up event line
`timescale 1ns/1ps
`default_nettype none
module simov_front
  import simov_pkg::*;
(
  input  wire logic                                  run,
  input  wire logic [3*simov_pkg::NUM_INPUTS-1:0]    voltCode,
  input  wire logic                                  eventReqNOut,
  input  wire logic                                  eventReqNOe,
  output logic                                       pollClk,
  output logic [simov_pkg::NUM_INPUTS*simov_pkg::NUM_LEVELS-1:0] inAbove,
  output logic                                       eventLineN
);
  import simov_pkg::*;
  // Odd offset keeps poll edges unrelated to the system clock
  initial begin
    pollClk = 1'b0;
    #37;
    forever begin
      #400;
      pollClk = run ? ~pollClk : 1'b0;
    end
  end
  // Code v means above levels 0..v-1
  always_comb begin
    for (int i = 0; i < NUM_INPUTS; i++) begin
      for (int l = 0; l < NUM_LEVELS; l++) begin
        inAbove[i*4+l] = (voltCode[3*i+:3] > 3'(l));
      end
    end
  end
  // Pull-up holds the line high when released
  assign eventLineN = eventReqNOe ? eventReqNOut : 1'b1;
endmodule : simov_front
`default_nettype wire

// File: tb/simov_monitor_props.sv
// Checker: port-level properties of the switch monitor
`timescale 1ns/1ps
`default_nettype none
module simov_monitor_props
  import simov_pkg::*;
(
  input wire logic                          ref_clk,
  input wire logic                          rst,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [7:0]                    paddr,
  input wire logic [31:0]                   prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire logic                          ovDetect,
  input wire logic [simov_pkg::NUM_INPUTS-1:0] wettingOn,
  input wire logic [simov_pkg::NUM_INPUTS-1:0] sinkSel,
  input wire logic [simov_pkg::NUM_INPUTS*simov_pkg::WC_W-1:0] wettingCode,
  input wire logic                          eventReqNOe
);
  import simov_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****************************************************************
  // Sequences
  // ****************************************************************
  // Comparator quiet long enough that no event can land on the read
  sequence s_quiet;
    $stable(ovDetect) [*6];
  endsequence
  sequence s_evt_read;
    psel && penable && pready && !pwrite && paddr == OFF_EVENT;
  endsequence
  sequence s_xfer;
    psel && !penable ##1 psel && penable;
  endsequence
  // ****************************************************************
  // Properties
  // ****************************************************************
  a_wet_off: assert property (ovDetect [*5] |-> wettingOn == '0)
    else $error("wetting current on during over-voltage");
  a_ov_line: assert property ($rose(ovDetect) |-> ##[1:5] eventReqNOe)
    else $error("event line not pulled on over-voltage");
  a_any_flag: assert property (s_xfer ##0 !pwrite |->
    prdata[31] == $past(eventReqNOe))
    else $error("any-event flag wrong in read data");
  a_rd_clear: assert property (s_quiet ##0 s_evt_read |=> ##1 !eventReqNOe)
    else $error("event line kept after event read");
  a_ready_acc: assert property (s_xfer |-> pready)
    else $error("no ready in access phase");
  a_bad_addr: assert property (psel && penable && paddr > OFF_WC_B |-> pslverr)
    else $error("unmapped access not flagged");
  a_sink_hi: assert property (sinkSel[23:10] == '0)
    else $error("sink selected on source-only input");
  a_wet_pair: assert property (wettingCode[5:3] == wettingCode[2:0] &&
    wettingCode[23:21] == wettingCode[20:18] &&
    wettingCode[65:63] == wettingCode[62:60])
    else $error("paired inputs differ in wetting code");
endmodule : simov_monitor_props
bind simov_monitor simov_monitor_props u_props (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ovDetect(ovDetect), .wettingOn(wettingOn),
  .sinkSel(sinkSel), .wettingCode(wettingCode), .eventReqNOe(eventReqNOe));
`default_nettype wire

// File: tb/tb.sv
// Testbench: self-checking run of the switch monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
  import simov_pkg::*;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        ovDetect, pollClk, eventReqNOut, eventReqNOe, run, eventLineN;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        errBit;
  logic [95:0] inAbove;
  logic [23:0] wettingOn, sinkSel;
  logic [71:0] wettingCode, voltCode;
  int          errCount, samplesChecked;
  logic [7:0]  cfgOff [6] = '{OFF_CONFIG, OFF_IN_EN, OFF_CS_SEL,
                              OFF_THRESH, OFF_WC_A, OFF_WC_B};
  simov_monitor dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ovDetect(ovDetect), .pollClk(pollClk), .inAbove(inAbove),
    .wettingOn(wettingOn), .sinkSel(sinkSel), .wettingCode(wettingCode),
    .eventReqNOut(eventReqNOut), .eventReqNOe(eventReqNOe));
  simov_front u_front (.run(run), .voltCode(voltCode),
    .eventReqNOut(eventReqNOut), .eventReqNOe(eventReqNOe),
    .pollClk(pollClk), .inAbove(inAbove), .eventLineN(eventLineN));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic finishTest();
    $display("errors %0d, checks %0d", errCount, samplesChecked);
    if (errCount == 0 && samplesChecked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finishTest
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang(input int n);
    if (n >= 400) begin
      errCount++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      finishTest();
    end
  endtask : hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 400) begin
      n++;
      @(posedge ref_clk);
    end
    hang(n);
    rd     = prdata;
    errBit = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Let the write's register update settle before callers look at outputs
    @(negedge ref_clk);
  endtask : apb
  task automatic waitLow();
    int n = 0;
    while (eventLineN !== 1'b0 && n < 400) begin
      n++;
      @(posedge ref_clk);
    end
    hang(n);
  endtask : waitLow
  // Runs one poll cycle, then stops the poll clock and reads the event
  task automatic pollOnce(input logic [31:0] status);
    run <= 1'b1;
    waitLow();
    run <= 1'b0;
    repeat (12) @(posedge ref_clk);
    apb(1'b0, OFF_EVENT, '0);
    chk(rd, 32'h80000002);
    apb(1'b0, OFF_SWSTAT, '0);
    chk(rd, status);
  endtask : pollOnce
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic tReset();
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, cfgOff[i], '0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h40, '0);
    chk(rd, 32'h0);
    chk({31'h0, errBit}, 32'h1);
    apb(1'b0, OFF_CONFIG, '0);
    chk({31'h0, errBit}, 32'h0);
  endtask : tReset
  task automatic tConfig();
    apb(1'b1, OFF_IN_EN, 32'h0000000F);
    apb(1'b1, OFF_CS_SEL, 32'h000003FF);
    chk({8'h00, sinkSel}, 32'h000003FF);
    apb(1'b1, OFF_WC_A, 32'h0022C688);
    chk({2'b00, wettingCode[29:0]}, 32'h2D91A240);
    apb(1'b1, OFF_THRESH, 32'h00000002);
    apb(1'b1, OFF_CONFIG, 32'h00000001);
    chk({8'h00, wettingOn}, 32'h0000000F);
    apb(1'b1, OFF_IN_EN, 32'h000000FF);
    apb(1'b0, OFF_IN_EN, '0);
    chk(rd, 32'h0000000F);
  endtask : tConfig
  task automatic tOver();
    ovDetect <= 1'b1;
    waitLow();
    chk({8'h00, wettingOn}, 32'h0);
    apb(1'b0, OFF_MISC, '0);
    chk(rd, 32'h80000001);
    apb(1'b0, OFF_EVENT, '0);
    chk(rd, 32'h80000001);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, eventLineN}, 32'h1);
    apb(1'b0, OFF_CS_SEL, '0);
    chk(rd, 32'h000003FF);
    repeat (20) @(posedge ref_clk);
    chk({31'h0, eventLineN}, 32'h1);
    ovDetect <= 1'b0;
    waitLow();
    apb(1'b0, OFF_MISC, '0);
    chk(rd, 32'h80000000);
    apb(1'b0, OFF_EVENT, '0);
    chk(rd, 32'h80000001);
    chk({8'h00, wettingOn}, 32'h0000000F);
  endtask : tOver
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    {rst, psel, penable, pwrite, ovDetect, run} = 6'b100000;
    {paddr, pwdata, errCount, samplesChecked} = '0;
    voltCode = {60'h0, 3'd0, 3'd4, 3'd2, 3'd3};
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    tReset();
    tConfig();
    tOver();
    pollOnce(32'h00000005);
    apb(1'b1, OFF_CONFIG, '0);
    apb(1'b1, OFF_THRESH, '0);
    apb(1'b1, OFF_CONFIG, 32'h00000001);
    pollOnce(32'h00000007);
    finishTest();
  end
endmodule : tb
`default_nettype wire
